// ---- rci_clist_entry.sv ----
`timescale 1ns/1ns
`default_nettype none
// Checks one channel-list entry of three characters
module rci_clist_entry
  import rci_pkg::*;
(
  input  wire logic [23:0] entry,   // Slot char in top byte
  output logic             ok,      // Entry well formed
  output logic [8:0]       code     // Slot in [8:7], channel in [6:0]
);

  import rci_pkg::*;

  logic [7:0] slot_c;   // Slot digit character
  logic [7:0] tens_c;   // Channel tens character
  logic [7:0] ones_c;   // Channel ones character
  logic [3:0] tens;     // Tens value
  logic [3:0] ones;     // Ones value

  // Split and validate the characters
  always_comb begin
    slot_c = entry[23:16];
    tens_c = entry[15:8];
    ones_c = entry[7:0];
    tens   = tens_c[3:0];
    ones   = ones_c[3:0];
    ok = (slot_c == ASCII_ONE || slot_c == ASCII_TWO) &&
         (tens_c >= ASCII_ZERO) && (tens_c <= ASCII_NINE) &&
         (ones_c >= ASCII_ZERO) && (ones_c <= ASCII_NINE);
    // Ten times tens plus ones fits seven bits
    code = {(slot_c == ASCII_ONE) ? 2'h1 : 2'h2,
            7'({3'h0, tens} * 7'd10 + {3'h0, ones})};
  end

endmodule
`default_nettype wire

// ---- rci_core.sv ----
`timescale 1ns/1ns
`default_nettype none
// Common and measurement command interpreter
module rci_core
  import rci_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     cmd_valid,
  output logic                          cmd_ready,
  input  wire rci_pkg::rci_op_t         cmd_op,
  input  wire logic [1:0]               cmd_arg,
  input  wire logic [rci_pkg::FUNC_W-1:0] cmd_func,
  input  wire logic [2:0]               p_present,
  input  wire logic [2:0]               p_clist,
  input  wire logic [15:0]              p_num0,
  input  wire logic [15:0]              p_num1,
  input  wire logic [23:0]              clist_first,
  input  wire logic [23:0]              clist_last,
  input  wire logic [3:0]               clist_cnt,
  input  wire logic                     clist_range,
  input  wire logic [15:0]              card_model0,
  input  wire logic [15:0]              card_model1,
  input  wire logic                     tst_pass,
  input  wire logic                     tm_idle,
  input  wire logic                     tm_moving,
  input  wire logic                     scanning,
  input  wire logic                     set_valid,
  input  wire logic [rci_pkg::CFG_W-1:0] set_data,
  output logic [rci_pkg::CFG_W-1:0]     cfg,
  output logic                          resp_valid,
  output rci_pkg::rci_resp_t            resp_kind,
  output logic [15:0]                   resp_data,
  output logic                          resp_last,
  output logic                          err_valid,
  output logic [15:0]                   err_code,
  output logic                          bus_trig,
  output logic                          init_req,
  output logic                          abort_req,
  output logic                          fetch_req,
  output logic                          conf_req,
  output logic [rci_pkg::FUNC_W-1:0]    conf_func,
  output logic [15:0]                   conf_range,
  output logic [15:0]                   conf_res,
  output logic                          conf_range_vld,
  output logic                          conf_res_vld,
  output logic                          conf_clist_vld,
  output logic [8:0]                    conf_first,
  output logic [8:0]                    conf_last,
  output logic                          opc_event,
  output logic                          flush
);

  import rci_pkg::*;

  // Whole state of the interpreter
  typedef struct packed {
    rci_state_t                  st;
    logic [SLOTS-1:0][CFG_W:0]   mem;       // Parity on top bit
    logic [CFG_W-1:0]            cfg;
    logic                        init_pend; // Initiate still running
    logic                        init_busy; // Trigger model left idle
    logic                        trg_pend;  // Trigger still moving
    logic                        opc_owed;  // Completion event owed
    logic                        meas;      // Sequence is a measure
    logic                        opt_idx;
    logic                        run_busy;
    logic [FUNC_W-1:0]           func;
    logic [15:0]                 rng;
    logic [15:0]                 res;
    logic                        rng_v;
    logic                        res_v;
    logic                        cl_v;
    logic [8:0]                  cl_first;
    logic [8:0]                  cl_last;
    logic                        cmd_ready;
    logic                        resp_valid;
    rci_resp_t                   resp_kind;
    logic [15:0]                 resp_data;
    logic                        resp_last;
    logic                        err_valid;
    logic [15:0]                 err_code;
    logic                        bus_trig;
    logic                        init_req;
    logic                        abort_req;
    logic                        fetch_req;
    logic                        conf_req;
    logic                        opc_event;
    logic                        flush;
  } rci_regs_t;

  rci_regs_t r;        // Registered state
  rci_regs_t next_r;   // Next state

  logic       take;        // Command accepted this cycle
  logic       ok_first;    // First entry well formed
  logic       ok_last;     // Last entry well formed
  logic [8:0] code_first;  // Decoded first entry
  logic [8:0] code_last;   // Decoded last entry
  logic       syn_err;     // Parameter syntax fault
  logic       rng_in;      // Range given
  logic       res_in;      // Resolution given
  logic       cl_in;       // Channel list given
  logic       all_done;    // No overlapped work left
  logic       rst_peek;    // Reset waiting behind a hold
  logic [1:0] arm_src;     // Programmed arm source

  // Entry checkers for both ends of the list
  rci_clist_entry u_first (
    .entry (clist_first),
    .ok    (ok_first),
    .code  (code_first)
  );
  rci_clist_entry u_last (
    .entry (clist_last),
    .ok    (ok_last),
    .code  (code_last)
  );

  // Parameter decode shared by configure and measure
  always_comb begin
    cl_in   = |p_clist;
    syn_err = ((p_clist & (p_clist - 3'h1)) != 3'h0) ||
              (p_clist[0] && (|p_present[2:1])) ||
              (p_clist[1] && p_present[2]) ||
              (p_clist[2] && !p_present[2]);
    if (cl_in && (!ok_first || (clist_range && !ok_last))) begin
      syn_err = 1'b1;
    end
    if (cmd_op == OP_MEAS && cl_in && (clist_cnt > 4'h1 || clist_range)) begin
      syn_err = 1'b1;
    end
    rng_in = p_present[0] && !p_clist[0];
    res_in = p_present[1] && !p_clist[1] && rng_in;
  end

  assign take     = cmd_valid && r.cmd_ready;
  assign arm_src  = r.cfg[ARM_HI:ARM_LO];
  // Reset may break a hold so it is never stuck behind one
  assign rst_peek = cmd_valid && cmd_op == OP_RST;
  assign all_done = !r.init_pend && !r.trg_pend;

  // Next-state logic
  always_comb begin
    next_r            = r;
    next_r.resp_valid = 1'b0;
    next_r.resp_last  = 1'b0;
    next_r.err_valid  = 1'b0;
    next_r.bus_trig   = 1'b0;
    next_r.init_req   = 1'b0;
    next_r.abort_req  = 1'b0;
    next_r.fetch_req  = 1'b0;
    next_r.conf_req   = 1'b0;
    next_r.opc_event  = 1'b0;
    next_r.flush      = 1'b0;

    // Other handlers change the live settings
    if (set_valid) begin
      next_r.cfg = set_data;
    end

    // initiate ends on return to idle
    if (r.init_pend && !tm_idle) begin
      next_r.init_busy = 1'b1;
    end
    if (r.init_pend && r.init_busy && tm_idle) begin
      next_r.init_pend = 1'b0;
      next_r.init_busy = 1'b0;
    end
    if (r.trg_pend && !r.bus_trig && !tm_moving) begin
      next_r.trg_pend = 1'b0;
    end
    // Owed completion event fires once all work is over
    if (r.opc_owed && all_done) begin
      next_r.opc_owed  = 1'b0;
      next_r.opc_event = 1'b1;
    end

    unique case (r.st)
      S_IDLE: begin
        if (take) begin
          unique case (cmd_op)
            OP_OPT: begin
              next_r.opt_idx = 1'b0;
              next_r.st      = S_OPT;
            end
            OP_SAV: begin
              next_r.mem[cmd_arg] = {^r.cfg, r.cfg};
            end
            OP_RCL: begin
              if (^r.mem[cmd_arg] == 1'b0) begin
                next_r.cfg = r.mem[cmd_arg][CFG_W-1:0];
              end else begin
                next_r.mem[cmd_arg] = {^PRESET_VALUE, PRESET_VALUE};
                next_r.cfg          = PRESET_VALUE;
              end
            end
            OP_RST: begin
              next_r.cfg       = RST_DEFAULT;
              next_r.opc_owed  = 1'b0;
              next_r.opc_event = 1'b0;
              next_r.init_pend = 1'b0;
              next_r.init_busy = 1'b0;
              next_r.trg_pend  = 1'b0;
              next_r.flush     = 1'b1;
              next_r.abort_req = 1'b1;
            end
            OP_TRG: begin
              if (arm_src == ARM_BUS) begin
                next_r.bus_trig = 1'b1;
                next_r.trg_pend = 1'b1;
              end
            end
            OP_TST: begin
              next_r.resp_valid = 1'b1;
              next_r.resp_kind  = RESP_NUM;
              next_r.resp_data  = tst_pass ? ASCII_0 : ASCII_1;
              next_r.resp_last  = 1'b1;
            end
            OP_WAI: begin
              next_r.st = S_WAI;
            end
            OP_OPC: begin
              next_r.opc_owed = 1'b1;
            end
            OP_OPCQ: begin
              next_r.st = S_OPCQ;
            end
            OP_INIT: begin
              next_r.init_req  = 1'b1;
              next_r.init_pend = 1'b1;
              next_r.init_busy = 1'b0;
            end
            OP_INIT_CONT: begin
              next_r.cfg[CONT_BIT] = 1'b1;
              next_r.init_req      = 1'b1;
              next_r.init_pend     = 1'b1;
              next_r.init_busy     = 1'b0;
            end
            OP_ABORT: begin
              next_r.abort_req     = 1'b1;
              next_r.cfg[CONT_BIT] = 1'b0;
              next_r.init_pend     = 1'b0;
              next_r.init_busy     = 1'b0;
            end
            OP_FETCH: begin
              next_r.fetch_req = 1'b1;
            end
            OP_READ: begin
              next_r.meas = 1'b0;
              next_r.st   = S_ABORT;
            end
            // Configure and measure share the checks
            default: begin
              next_r.func     = cmd_func;
              next_r.rng      = p_num0;
              next_r.res      = p_num1;
              next_r.rng_v    = rng_in;
              // Resolution is dropped when a list is given
              next_r.res_v    = res_in && !cl_in;
              next_r.cl_v     = cl_in;
              next_r.cl_first = code_first;
              next_r.cl_last  = clist_range ? code_last : code_first;
              if (syn_err) begin
                next_r.err_valid = 1'b1;
                next_r.err_code  = ERR_SYNTAX;
              end else if ((cmd_func == FUNC_TEMP || cmd_func == FUNC_CONT) &&
                           (rng_in || res_in)) begin
                next_r.err_valid = 1'b1;
                next_r.err_code  = ERR_NOT_ALLOWED;
              end else if (scanning) begin
                next_r.err_valid = 1'b1;
                next_r.err_code  = ERR_CONFLICT;
              end else if (cmd_op == OP_CONF) begin
                next_r.conf_req = 1'b1;
              end else begin
                next_r.meas = 1'b1;
                next_r.st   = S_ABORT;
              end
            end
          endcase
        end
      end
      S_WAI: begin
        if (rst_peek || all_done) begin
          next_r.st = S_IDLE;
        end
      end
      S_OPCQ: begin
        if (rst_peek) begin
          next_r.st = S_IDLE;
        end else if (all_done) begin
          next_r.resp_valid = 1'b1;
          next_r.resp_kind  = RESP_NUM;
          next_r.resp_data  = ASCII_1;
          next_r.resp_last  = 1'b1;
          next_r.st         = S_IDLE;
        end
      end
      S_OPT: begin
        next_r.resp_valid = 1'b1;
        next_r.resp_data  = r.opt_idx ? card_model1 : card_model0;
        next_r.resp_kind  = (next_r.resp_data == 16'h0000) ? RESP_NONE : RESP_MODEL;
        next_r.resp_last  = r.opt_idx;
        next_r.opt_idx    = 1'b1;
        if (r.opt_idx) begin
          next_r.st = S_IDLE;
        end
      end
      S_ABORT: begin
        next_r.abort_req     = 1'b1;
        next_r.cfg[CONT_BIT] = 1'b0;
        next_r.init_pend     = 1'b0;
        next_r.init_busy     = 1'b0;
        next_r.st            = r.meas ? S_CONF : S_INIT;
      end
      S_CONF: begin
        next_r.conf_req = 1'b1;
        next_r.st       = S_INIT;
      end
      S_INIT: begin
        next_r.init_req = 1'b1;
        next_r.run_busy = 1'b0;
        next_r.st       = S_RUN;
      end
      S_RUN: begin
        if (!tm_idle) begin
          next_r.run_busy = 1'b1;
        end
        if (r.run_busy && tm_idle) begin
          next_r.st = S_FETCH;
        end
      end
      S_FETCH: begin
        next_r.fetch_req = 1'b1;
        next_r.st        = S_IDLE;
      end
    endcase

    next_r.cmd_ready = (next_r.st == S_IDLE);

    if (rst) begin
      next_r           = '0;
      next_r.st        = S_IDLE;
      next_r.cfg       = RST_DEFAULT;
      next_r.cmd_ready = 1'b1;
      for (int i = 0; i < SLOTS; i++) begin
        next_r.mem[i] = {^PRESET_VALUE, PRESET_VALUE};
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // Outputs straight from the state register
  assign cmd_ready      = r.cmd_ready;
  assign cfg            = r.cfg;
  assign resp_valid     = r.resp_valid;
  assign resp_kind      = r.resp_kind;
  assign resp_data      = r.resp_data;
  assign resp_last      = r.resp_last;
  assign err_valid      = r.err_valid;
  assign err_code       = r.err_code;
  assign bus_trig       = r.bus_trig;
  assign init_req       = r.init_req;
  assign abort_req      = r.abort_req;
  assign fetch_req      = r.fetch_req;
  assign conf_req       = r.conf_req;
  assign conf_func      = r.func;
  assign conf_range     = r.rng;
  assign conf_res       = r.res;
  assign conf_range_vld = r.rng_v;
  assign conf_res_vld   = r.res_v;
  assign conf_clist_vld = r.cl_v;
  assign conf_first     = r.cl_first;
  assign conf_last      = r.cl_last;
  assign opc_event      = r.opc_event;
  assign flush          = r.flush;

  // Checks on the interpreter
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  opt_two_entries_a: assert property (
    take && cmd_op == OP_OPT |=> ##1 (resp_valid && !resp_last) ##1 (resp_valid && resp_last))
    else $error("option answer not two entries");
  recall_value_a: assert property (
    take && cmd_op == OP_RCL && !set_valid |=> cfg == $past(r.mem[cmd_arg][CFG_W-1:0]) || cfg == PRESET_VALUE)
    else $error("recall did not restore setup");
  reset_cleanup_a: assert property (
    take && cmd_op == OP_RST && !set_valid |=> cfg == RST_DEFAULT && flush && !r.opc_owed && !r.trg_pend)
    else $error("reset left state behind");
  trig_gate_a: assert property (
    bus_trig |-> $past(arm_src) == ARM_BUS)
    else $error("trigger sent without BUS arm");
  self_test_a: assert property (
    take && cmd_op == OP_TST |=> resp_valid && resp_data == ($past(tst_pass) ? ASCII_0 : ASCII_1))
    else $error("self test answer wrong");
  wait_hold_a: assert property (
    r.st == S_WAI && !all_done && !rst_peek |=> !cmd_ready)
    else $error("wait released early");
  read_order_a: assert property (
    take && cmd_op == OP_READ |=> r.st == S_ABORT ##1 (abort_req && r.st == S_INIT) ##1 init_req)
    else $error("read sequence out of order");
  scan_refuse_a: assert property (
    take && cmd_op == OP_CONF && scanning && !syn_err && !rng_in |=> err_valid && err_code == ERR_CONFLICT && !conf_req)
    else $error("configure accepted while scanning");
  opcq_done_a: assert property (
    resp_valid && $past(r.st) == S_OPCQ |-> $past(all_done))
    else $error("completion answer too early");

endmodule
`default_nettype wire

// ---- rci_pkg.sv ----
// Behaviour
// - Option query lists each slot's model or NONE
// - Four setup slots 0-3: save, recall
// - Save captures all reset-affected settings
// - Failed recall loads system preset into memory
// - All slots hold preset before first save
// - Reset: defaults, flush pending, drop owed completions
// - Bus-trigger command acts as group trigger
// - Bus trigger acts only under BUS arm
// - Self-test returns 0 pass, 1 fail
// - Wait holds commands until overlapped work ends or a reset command is offered
// - Only initiate, continuous-on, trigger overlap
// - Sequential command finishes before next starts
// - Initiate done only when back in idle
// - Wait after trigger releases once pointer settles
// - Read runs abort, initiate, fetch
// - Measure runs abort, configure, read
// - Entry: slot 1/2 then two-digit channel
// - Measure accepts only one channel
// - Parameter after channel list raises -102
// - Plain parameters are range then resolution
// - Temperature/continuity with range/resolution raise -108
// - Configure/measure while scanning raise -221
// - Operation-complete query answers 1 when done
package rci_pkg;

  // Setup word and its fields
  localparam int          CFG_W        = 16;
  localparam int          ARM_LO       = 0;
  localparam int          ARM_HI       = 1;
  localparam int          CONT_BIT     = 2;
  localparam logic [1:0]  ARM_BUS      = 2'h1;
  localparam logic [15:0] RST_DEFAULT  = 16'h0000;
  localparam logic [15:0] PRESET_VALUE = 16'h0004;
  localparam int          SLOTS        = 4;
  localparam int          CARDS        = 2;

  // Measurement function codes
  localparam int          FUNC_W       = 3;
  localparam logic [2:0]  FUNC_TEMP    = 3'h6;
  localparam logic [2:0]  FUNC_CONT    = 3'h7;

  // Two's complement error numbers
  localparam logic [15:0] ERR_SYNTAX   = 16'hFF9A;
  localparam logic [15:0] ERR_NOT_ALLOWED = 16'hFF94;
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;

  // Answer characters
  localparam logic [15:0] ASCII_0      = 16'h0030;
  localparam logic [15:0] ASCII_1      = 16'h0031;
  localparam logic [7:0]  ASCII_ZERO   = 8'h30;
  localparam logic [7:0]  ASCII_ONE    = 8'h31;
  localparam logic [7:0]  ASCII_TWO    = 8'h32;
  localparam logic [7:0]  ASCII_NINE   = 8'h39;

  // Decoded command opcodes
  typedef enum logic [3:0] {
    OP_OPT = 4'h0, OP_SAV = 4'h1, OP_RCL = 4'h2, OP_RST = 4'h3,
    OP_TRG = 4'h4, OP_TST = 4'h5, OP_WAI = 4'h6, OP_OPC = 4'h7,
    OP_OPCQ = 4'h8, OP_INIT = 4'h9, OP_INIT_CONT = 4'hA, OP_ABORT = 4'hB,
    OP_CONF = 4'hC, OP_FETCH = 4'hD, OP_READ = 4'hE, OP_MEAS = 4'hF
  } rci_op_t;

  // Answer kinds on the response port
  typedef enum logic [1:0] {
    RESP_NUM = 2'h0, RESP_MODEL = 2'h1, RESP_NONE = 2'h2
  } rci_resp_t;

  // Interpreter states, one-hot
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001, S_WAI  = 9'h002, S_OPCQ = 9'h004,
    S_OPT   = 9'h008, S_ABORT = 9'h010, S_CONF = 9'h020,
    S_INIT  = 9'h040, S_RUN  = 9'h080, S_FETCH = 9'h100
  } rci_state_t;

endpackage

// ---- rci_tm_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Trigger model stand-in on the far side of the core
module rci_tm_model
  import rci_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic init_req,
  input  wire logic abort_req,
  input  wire logic bus_trig,
  output logic      tm_idle,
  output logic      tm_moving
);
  logic [3:0] run_cnt; // Cycles left out of idle
  logic [1:0] mv_cnt;  // Cycles left of pointer motion
  // Motion is seen in the trigger cycle itself, as the core expects
  // pointer settles later
  assign tm_moving = bus_trig | (mv_cnt != 2'h0);
  assign tm_idle   = (run_cnt == 4'h0);
  // Leave idle on initiate, return after a slow run
  // idle return
  always_ff @(posedge clk) begin
    if (rst || abort_req) begin
      run_cnt <= 4'h0;
      mv_cnt  <= 2'h0;
    end else begin
      // Long run so a hold that lets go too early finds the model still busy
      run_cnt <= init_req ? 4'hF : (tm_idle ? 4'h0 : run_cnt - 4'h1);
      mv_cnt  <= bus_trig ? 2'h2 : (mv_cnt != 2'h0 ? mv_cnt - 2'h1 : 2'h0);
    end
  end
endmodule
`default_nettype wire

// ---- remote_common_command_interpreter_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the command core
module remote_common_command_interpreter_bench;
  import rci_pkg::*;
  logic clk = 0, rst = 1, cv = 0, sv = 0, tp = 1, idl, mov;
  rci_op_t op = OP_OPT;
  logic [1:0] arg = 2'h0;
  logic [2:0] fn = 3'h0, pp = 3'h0, pc = 3'h0;
  logic [3:0] cnt = 4'h1;
  logic sc = 0;
  logic [15:0] sd = 16'h0000, m0 = 16'h0000, cfg, rd, ec, last_err;
  logic rdy, rv, ev, trg, ini, abo, cr, rl, fch, oe, fl, cvl, rvl, svl, rg = 0;
  logic [1:0] rk;
  logic [2:0] cfn, kq[$]; // Function seen; kind and last flag per answer
  logic [8:0] cfi, cla;
  logic [15:0] crg, crs;
  logic [15:0] rq[$]; // Answers seen
  int n_mismatch = 0, cmp_count = 0, n_trig = 0, n_conf = 0, i, n0;
  int n_fetch = 0, n_opc = 0, n_flush = 0;
  // Case rows: func, present, clist, scanning, expected error
  logic [25:0] rows [5] = '{
    {3'h6, 3'h1, 3'h0, 1'b0, ERR_NOT_ALLOWED}, {3'h0, 3'h3, 3'h1, 1'b0, ERR_SYNTAX},
    {3'h0, 3'h0, 3'h0, 1'b1, ERR_CONFLICT}, {3'h0, 3'h3, 3'h0, 1'b0, 16'h0000},
    {3'h6, 3'h1, 3'h1, 1'b0, 16'h0000}};
  always #25 clk = ~clk;
  rci_core u_rci_core (.clk(clk), .rst(rst), .cmd_valid(cv), .cmd_ready(rdy), .cmd_op(op),
    .cmd_arg(arg), .cmd_func(fn), .p_present(pp), .p_clist(pc), .p_num0(16'h000a),
    .p_num1(16'h0001), .clist_first(24'h31_3031), .clist_last(24'h31_3130), .clist_cnt(cnt),
    .clist_range(rg), .card_model0(m0), .card_model1(16'h0000), .tst_pass(tp),
    .tm_idle(idl), .tm_moving(mov), .scanning(sc), .set_valid(sv), .set_data(sd), .cfg(cfg),
    .resp_valid(rv), .resp_kind(rk), .resp_data(rd), .resp_last(rl), .err_valid(ev),
    .err_code(ec), .bus_trig(trg), .init_req(ini), .abort_req(abo), .fetch_req(fch),
    .conf_req(cr), .conf_func(cfn), .conf_range(crg), .conf_res(crs), .conf_range_vld(rvl),
    .conf_res_vld(svl), .conf_clist_vld(cvl), .conf_first(cfi), .conf_last(cla), .opc_event(oe),
    .flush(fl));
  rci_tm_model u_rci_tm_model (.clk(clk), .rst(rst), .init_req(ini), .abort_req(abo),
    .bus_trig(trg), .tm_idle(idl), .tm_moving(mov));
  // Catch one-cycle pulses at the edge where they stand
  always @(posedge clk) begin
    if (ev === 1'b1) last_err <= ec;
    if (rv === 1'b1) begin
      rq.push_back(rd);
      kq.push_back({rk, rl});
    end
    if (trg === 1'b1) n_trig++;
    if (cr === 1'b1) n_conf++;
    if (fch === 1'b1) n_fetch++;
    if (oe === 1'b1) n_opc++;
    if (fl === 1'b1) n_flush++;
  end
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for the core to be ready at a falling edge
  task wrdy();
    for (i = 0; i < 300 && rdy !== 1'b1; i++) @(negedge clk);
    if (rdy !== 1'b1) begin
      chk(16'hdead, 16'h0000);
      summarize();
    end
  endtask
  // Offer one command, hold it to the taking edge, let answers land
  task cmd(input rci_op_t o, input logic [1:0] a);
    wrdy();
    op = o;
    arg = a;
    cv = 1'b1;
    @(negedge clk);
    cv = 1'b0;
    repeat (4) @(negedge clk);
    wrdy();
  endtask
  // Live setting written by another handler
  task set(input logic [15:0] v);
    sd = v;
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(cfg, RST_DEFAULT); // reset default
    chk({15'h0, rdy}, 16'h0001);
    // Case rows, then hand-written cases
    foreach (rows[k]) begin
      {fn, pp, pc, sc} = rows[k][25:16];
      last_err = 16'h0000;
      n0 = n_conf;
      cmd(OP_CONF, 2'h0);
      chk(last_err, rows[k][15:0]);
      chk(16'(n_conf - n0), {15'h0, rows[k][15:0] == 16'h0000});
    end
    // Last row left a one-entry list with no range
    chk({6'h0, cvl, cfi}, 16'h0281); // entry decoded
    chk({13'h0, cfn}, 16'h0006); // function kept
    {fn, pp, pc} = {3'h0, 3'h3, 3'h0};
    cmd(OP_CONF, 2'h0);
    chk({14'h0, rvl, svl}, 16'h0003); // range and resolution
    chk(crg, 16'h000a); // range value
    chk(crs, 16'h0001); // resolution value
    {pp, pc, rg} = {3'h1, 3'h1, 1'b1};
    cmd(OP_CONF, 2'h0);
    chk({7'h0, cla}, 16'h008a); // range end decoded
    chk({14'h0, rvl, svl}, 16'h0000); // list is no range
    {pp, pc, sc, cnt, rg} = {3'h1, 3'h1, 1'b0, 4'h2, 1'b0};
    cmd(OP_MEAS, 2'h0);
    chk(last_err, ERR_SYNTAX); // one channel
    {cnt, rg, last_err} = {4'h1, 1'b1, 16'h0000};
    cmd(OP_MEAS, 2'h0);
    chk(last_err, ERR_SYNTAX); // range refused
    rg = 1'b0;
    set(16'h0001);
    cmd(OP_TRG, 2'h0);
    chk(16'(n_trig), 16'h0001); // bus arm
    set(16'h0000);
    cmd(OP_TRG, 2'h0);
    chk(16'(n_trig), 16'h0001); // other arm
    set(16'h0009);
    cmd(OP_SAV, 2'h2);
    cmd(OP_RST, 2'h0);
    chk(cfg, RST_DEFAULT); // defaults
    chk(16'(n_flush), 16'h0001); // pending flushed
    cmd(OP_RCL, 2'h2);
    chk(cfg, 16'h0009); // restore
    m0 = 16'h1234;
    rq.delete();
    kq.delete();
    cmd(OP_OPT, 2'h0);
    chk(16'(rq.size()), 16'h0002); // two entries
    chk(rq[0], 16'h1234); // slot model
    chk({13'h0, kq[0]}, 16'h0002); // model, not last
    chk({13'h0, kq[1]}, 16'h0005); // empty slot, last
    rq.delete();
    cmd(OP_TST, 2'h0);
    tp = 1'b0;
    cmd(OP_TST, 2'h0);
    chk(rq[0], ASCII_0); // pass
    chk(rq[1], ASCII_1); // fail
    rq.delete();
    cmd(OP_INIT, 2'h0);
    chk({15'h0, idl}, 16'h0000); // left idle
    cmd(OP_OPCQ, 2'h0);
    // Answer and ready rise together; let one edge catch the answer
    @(negedge clk);
    chk({15'h0, idl}, 16'h0001); // done in idle
    chk(rq[0], ASCII_1); // answer
    cmd(OP_INIT_CONT, 2'h0);
    chk(cfg, 16'h000d); // continuous on
    cmd(OP_OPC, 2'h0);
    cmd(OP_WAI, 2'h0);
    chk({15'h0, idl}, 16'h0001); // held until idle
    cmd(OP_ABORT, 2'h0);
    chk(cfg, 16'h0009); // continuous off
    chk(16'(n_opc), 16'h0001); // completion event
    cmd(OP_INIT, 2'h0);
    cmd(OP_OPC, 2'h0);
    cmd(OP_RST, 2'h0);
    chk(16'(n_opc), 16'h0001); // owed event dropped
    cmd(OP_FETCH, 2'h0);
    cmd(OP_READ, 2'h0);
    {pp, pc, rg} = {3'h0, 3'h0, 1'b0};
    n0 = n_conf;
    cmd(OP_MEAS, 2'h0);
    // Fetch pulse rises with ready; one more edge to count it
    @(negedge clk);
    chk(16'(n_fetch), 16'h0003); // fetches done
    chk(16'(n_conf - n0), 16'h0001); // configure ran
    cmd(OP_RCL, 2'h1);
    chk(cfg, PRESET_VALUE); // factory preset
    summarize();
  end
endmodule
`default_nettype wire
